// ===== src/cpu_clk_pkg.sv
// constants for the cpu clock select and divide block
// assumes a 25 MHz system clock and an AXI4-Lite register port
package cpu_clk_pkg;
	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_CPU_DIV  = 16'hfffb;
	localparam logic [15:0] IDX_OSC_SEL  = 16'hfffc;
	localparam logic [15:0] IDX_DIV_SET  = 16'hfffd;
	localparam logic [15:0] IDX_DIV_CLR  = 16'hfffe;
	localparam int          ADDR_W       = 18;

	// cpu_clock_divider_control layout
	localparam logic [7:0]  DIV_RESET    = 8'h01;
	localparam logic [7:0]  DIV_WR_MASK  = 8'h57;
	localparam int          B_FORCE      = 6;
	localparam int          B_ON_SUB     = 5;
	localparam int          B_SUB_SEL    = 4;
	localparam logic [2:0]  DIV_MAX      = 3'h4;

	// oscillator_gain_pin_mode_select layout
	localparam logic [7:0]  OSC_RESET    = 8'h00;
	localparam logic [7:0]  OSC_WR_MASK  = 8'hf1;
	localparam int          B_MAIN_EXT   = 7;
	localparam int          B_MAIN_OSC   = 6;
	localparam int          B_SUB_EXT    = 5;
	localparam int          B_SUB_OSC    = 4;
	localparam int          B_GAIN       = 0;

	// pin modes
	localparam logic [1:0]  PIN_PORT     = 2'h0;
	localparam logic [1:0]  PIN_XTAL     = 2'h1;
	localparam logic [1:0]  PIN_EXT      = 2'h3;

	// axi responses
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_DECERR  = 2'h3;

	// timing
	localparam int          CLK_PERIOD_NS = 40;
	localparam int          HOLD_MIN_NS   = 4060;
	localparam int          HOLD_MAX_NS   = 16120;
	localparam int          HOLD_CYC      =
		(HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          HOLD_EXT_CLKS = 160;
	localparam int          MIN_INSTR_CLKS = 2;
	localparam int          SUB_DIV       = 2;
endpackage

// ===== src/cpu_clk_sel_div.sv
// cpu clock source select, divider, gain hold-off and pin mode decode
// assumes oscillator ticks and stop release arrive as same-clock pulses
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// How it works
// R1: software sets gain high above 10 MHz, low from 1 to 10 MHz.
// R2: software sets gain after reset before peripherals, changes it once.
// R3: gain set with crystal source stalls cpu clock 4.06 to 16.12 us.
// R4: gain set with external high-speed input stalls 160 external clocks.
// R5: stop release with gain set stalls cpu clock per source as above.
// R6: stop release on crystal source waits for oscillator stabilization.
// R7: main pin mode bits changed only while main oscillator is halted.
// R8: software writes zero to bits 1 to 3 of oscillator select.
// R9: subsystem pin mode bits act together with force-start bit.
// R10: force-start gives crystal; else ext,osc select port/xtal/port/ext.
// R11: subsystem mode bits changed only while cpu runs on main clock.
// R12: reset loads divider control with 01h, main clock over two.
// R13: divider control takes single-bit as well as whole-byte writes.
// R14: bit 5 is read-only status, 1 when cpu runs on subsystem clock.
// R15: select 0 with codes 000 to 100 divides main by 1 to 16.
// R16: select 1 with codes 000 to 100 gives subsystem clock over two.
// R17: peripheral clock stays undivided whatever cpu ratio is chosen.
// R18: software writes zero to bits 3 and 7 of divider control.
// R19: fastest instruction takes two cpu clocks.
// R20: main clock is high-speed or internal oscillator per mode register.
// R21: switching is glitch-free; status follows the clock actually used.
module cpu_clk_sel_div (
	input  wire logic        i_clk,          // 25 MHz system clock
	input  wire logic        i_rst_b,        // sync reset, active low
	input  wire logic        i_ce,           // freezes all state when low
	input  wire logic [17:0] i_awaddr,       // axi write address
	input  wire logic        i_awvalid,      // axi write address valid
	output logic             o_awready,      // axi write address ready
	input  wire logic [31:0] i_wdata,        // axi write data
	input  wire logic [3:0]  i_wstrb,        // axi write strobes
	input  wire logic        i_wvalid,       // axi write data valid
	output logic             o_wready,       // axi write data ready
	output logic [1:0]       o_bresp,        // axi write response
	output logic             o_bvalid,       // axi write response valid
	input  wire logic        i_bready,       // axi write response ready
	input  wire logic [17:0] i_araddr,       // axi read address
	input  wire logic        i_arvalid,      // axi read address valid
	output logic             o_arready,      // axi read address ready
	output logic [31:0]      o_rdata,        // axi read data
	output logic [1:0]       o_rresp,        // axi read response
	output logic             o_rvalid,       // axi read data valid
	input  wire logic        i_rready,       // axi read data ready
	input  wire logic        i_main_src_hs,  // mode reg: main = high-speed
	input  wire logic        i_hs_tick,      // high-speed clock edge pulse
	input  wire logic        i_ih_tick,      // internal osc edge pulse
	input  wire logic        i_sub_tick,     // subsystem clock edge pulse
	input  wire logic        i_stop_release, // pulse: stop mode released
	input  wire logic        i_osc_stable,   // stabilization count done
	output logic             o_cpu_clk_en,   // cpu clock enable pulse
	output logic             o_periph_clk_en,// undivided peripheral enable
	output logic             o_cpu_held,     // cpu clock withheld
	output logic             o_cpu_on_sub,   // cpu runs on subsystem clock
	output logic             o_drive_gain_high, // oscillator gain high
	output logic [1:0]       o_main_pin_mode,// main pins: port/xtal/ext
	output logic [1:0]       o_sub_pin_mode, // sub pins: port/xtal/ext
	output logic [5:0]       o_min_instr_ticks // source ticks per 2 clocks
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_HOLD_TIME = 4'h2,
		ST_HOLD_EXT = 4'h4,
		ST_WAIT_STAB = 4'h8
	} hold_state_t;
	function automatic logic [3:0] div_limit(input logic [2:0] code);
		div_limit = 4'((5'h1 << code) - 5'h1);
	endfunction
	function automatic logic [1:0] pin_mode(input logic ext,
		input logic osc);
		if (!osc)
			pin_mode = cpu_clk_pkg::PIN_PORT;
		else if (ext)
			pin_mode = cpu_clk_pkg::PIN_EXT;
		else
			pin_mode = cpu_clk_pkg::PIN_XTAL;
	endfunction
	function automatic logic [15:0] idx_of(input logic [17:0] addr);
		idx_of = addr[17:2];
	endfunction
	logic [7:0]  div_reg_q, div_reg_d;
	logic [7:0]  osc_reg_q, osc_reg_d;
	logic        gain_done_q, gain_done_d;
	logic        aw_full_q, aw_full_d;
	logic [15:0] aw_idx_q, aw_idx_d;
	logic        w_full_q, w_full_d;
	logic [7:0]  w_byte_q, w_byte_d;
	logic        w_lane_q, w_lane_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        rvalid_q, rvalid_d;
	logic [1:0]  rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic        gain_rise;
	hold_state_t st_q, st_d;
	logic [8:0]  hold_cnt_q, hold_cnt_d;
	logic [3:0]  div_cnt_q, div_cnt_d;
	logic [2:0]  act_div_q, act_div_d;
	logic        act_sub_q, act_sub_d;
	logic        sub_ph_q, sub_ph_d;
	logic        cpu_en_q, cpu_en_d;
	logic        per_en_q, per_en_d;
	logic [5:0]  instr_q, instr_d;
	logic        main_tick, period_end, hs_ext, hs_xtal, do_write;
	logic [7:0]  wmask, div_new, osc_new;
	assign o_awready = i_ce && !aw_full_q && !bvalid_q;
	assign o_wready  = i_ce && !w_full_q && !bvalid_q;
	assign o_arready = i_ce && !rvalid_q;
	assign o_bvalid  = bvalid_q;
	assign o_bresp   = bresp_q;
	assign o_rvalid  = rvalid_q;
	assign o_rresp   = rresp_q;
	assign o_rdata   = rdata_q;
	assign do_write = aw_full_q && w_full_q && !bvalid_q;
	assign wmask    = w_byte_q & cpu_clk_pkg::DIV_WR_MASK & {8{w_lane_q}};
	always_comb begin
		aw_full_d = aw_full_q;
		aw_idx_d  = aw_idx_q;
		w_full_d  = w_full_q;
		w_byte_d  = w_byte_q;
		w_lane_d  = w_lane_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		div_reg_d = div_reg_q;
		osc_reg_d = osc_reg_q;
		gain_done_d = gain_done_q;
		div_new   = div_reg_q;
		osc_new   = osc_reg_q;
		gain_rise = 1'b0;
		if (o_awready && i_awvalid) begin
			aw_full_d = 1'b1;
			aw_idx_d  = idx_of(i_awaddr);
		end
		if (o_wready && i_wvalid) begin
			w_full_d = 1'b1;
			w_byte_d = i_wdata[7:0];
			w_lane_d = i_wstrb[0];
		end
		if (bvalid_q && i_bready)
			bvalid_d = 1'b0;
		if (do_write) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = cpu_clk_pkg::RESP_OKAY;
			case (aw_idx_q)
			cpu_clk_pkg::IDX_CPU_DIV:
				div_new = (div_reg_q & ~cpu_clk_pkg::DIV_WR_MASK)
					| wmask; // [R13]
			cpu_clk_pkg::IDX_DIV_SET:
				div_new = div_reg_q | wmask; // [R13]
			cpu_clk_pkg::IDX_DIV_CLR:
				div_new = div_reg_q & ~wmask; // [R13]
			cpu_clk_pkg::IDX_OSC_SEL: begin
				if (w_lane_q)
					osc_new = w_byte_q & cpu_clk_pkg::OSC_WR_MASK;
				// gain may change once per reset
				if (gain_done_q)
					osc_new[cpu_clk_pkg::B_GAIN] =
						osc_reg_q[cpu_clk_pkg::B_GAIN]; // [R2]
			end
			default:
				bresp_d = cpu_clk_pkg::RESP_DECERR;
			endcase
			// prohibited select/divide codes leave the old setting
			if (div_new[2:0] <= cpu_clk_pkg::DIV_MAX) // [R15] [R16]
				div_reg_d = div_new;
			else
				div_reg_d = {div_new[7:5], div_reg_q[4:0]};
			if (osc_new[cpu_clk_pkg::B_GAIN] !=
				osc_reg_q[cpu_clk_pkg::B_GAIN])
				gain_done_d = 1'b1;
			gain_rise = osc_new[cpu_clk_pkg::B_GAIN]
				&& !osc_reg_q[cpu_clk_pkg::B_GAIN];
			osc_reg_d = osc_new;
		end
	end
	always_comb begin
		rvalid_d = rvalid_q;
		rresp_d  = rresp_q;
		rdata_d  = rdata_q;
		if (rvalid_q && i_rready)
			rvalid_d = 1'b0;
		if (o_arready && i_arvalid) begin
			rvalid_d = 1'b1;
			rresp_d  = cpu_clk_pkg::RESP_OKAY;
			rdata_d  = 32'h0;
			case (idx_of(i_araddr))
			cpu_clk_pkg::IDX_CPU_DIV,
			cpu_clk_pkg::IDX_DIV_SET,
			cpu_clk_pkg::IDX_DIV_CLR: begin
				rdata_d[7:0] = div_reg_q & cpu_clk_pkg::DIV_WR_MASK;
				rdata_d[cpu_clk_pkg::B_ON_SUB] = act_sub_q; // [R14]
			end
			cpu_clk_pkg::IDX_OSC_SEL:
				rdata_d[7:0] = osc_reg_q;
			default:
				rresp_d = cpu_clk_pkg::RESP_DECERR;
			endcase
		end
	end
	assign main_tick = i_main_src_hs ? i_hs_tick : i_ih_tick; // [R20]
	assign hs_ext  = i_main_src_hs
		&& (o_main_pin_mode == cpu_clk_pkg::PIN_EXT);
	assign hs_xtal = i_main_src_hs
		&& (o_main_pin_mode == cpu_clk_pkg::PIN_XTAL);
	assign period_end = act_sub_q ? (i_sub_tick && sub_ph_q)
		: (main_tick && (div_cnt_q == div_limit(act_div_q)));
	// hold-off sequencer
	always_comb begin
		st_d = st_q;
		hold_cnt_d = hold_cnt_q;
		case (st_q)
		ST_IDLE: begin
			hold_cnt_d = 9'h0;
			if (!act_sub_q && i_stop_release && hs_xtal)
				st_d = ST_WAIT_STAB; // [R6]
			else if (!act_sub_q && hs_ext && (gain_rise ||
				(i_stop_release && osc_reg_q[cpu_clk_pkg::B_GAIN])))
				st_d = ST_HOLD_EXT; // [R4] [R5]
			else if (!act_sub_q && gain_rise && hs_xtal)
				st_d = ST_HOLD_TIME; // [R3]
			else if (!act_sub_q && !i_main_src_hs && i_stop_release
				&& osc_reg_q[cpu_clk_pkg::B_GAIN])
				st_d = ST_HOLD_TIME; // [R5]
		end
		ST_HOLD_TIME: begin
			hold_cnt_d = hold_cnt_q + 9'h1;
			if (hold_cnt_q == 9'(cpu_clk_pkg::HOLD_CYC - 1))
				st_d = ST_IDLE; // [R3] [R5]
		end
		ST_HOLD_EXT: begin
			if (i_hs_tick)
				hold_cnt_d = hold_cnt_q + 9'h1;
			if (i_hs_tick &&
				hold_cnt_q == 9'(cpu_clk_pkg::HOLD_EXT_CLKS - 1))
				st_d = ST_IDLE; // [R4] [R5]
		end
		ST_WAIT_STAB: begin
			if (i_osc_stable)
				st_d = ST_IDLE; // [R6]
		end
		default: begin
			st_d = ST_IDLE;
			hold_cnt_d = 9'h0;
		end
		endcase
	end
	// divider; new source and ratio are taken only at a period end
	always_comb begin
		div_cnt_d = div_cnt_q;
		sub_ph_d  = sub_ph_q;
		act_div_d = act_div_q;
		act_sub_d = act_sub_q;
		if (act_sub_q) begin
			if (i_sub_tick)
				sub_ph_d = !sub_ph_q; // [R16]
		end else if (main_tick) begin
			div_cnt_d = div_cnt_q + 4'h1; // [R15]
		end
		if (period_end) begin
			div_cnt_d = 4'h0;
			sub_ph_d  = 1'b0;
			act_div_d = div_reg_q[2:0]; // [R21]
			act_sub_d = div_reg_q[cpu_clk_pkg::B_SUB_SEL]; // [R21]
		end
		cpu_en_d = period_end && (st_q == ST_IDLE); // [R3] [R4] [R21]
		per_en_d = main_tick; // [R17]
		instr_d  = act_sub_q
			? 6'(cpu_clk_pkg::MIN_INSTR_CLKS * cpu_clk_pkg::SUB_DIV)
			: 6'(cpu_clk_pkg::MIN_INSTR_CLKS) << act_div_q; // [R19]
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			div_reg_q   <= cpu_clk_pkg::DIV_RESET; // [R12]
			osc_reg_q   <= cpu_clk_pkg::OSC_RESET;
			gain_done_q <= 1'b0;
			aw_full_q   <= 1'b0;
			aw_idx_q    <= 16'h0;
			w_full_q    <= 1'b0;
			w_byte_q    <= 8'h0;
			w_lane_q    <= 1'b0;
			bvalid_q    <= 1'b0;
			bresp_q     <= cpu_clk_pkg::RESP_OKAY;
			rvalid_q    <= 1'b0;
			rresp_q     <= cpu_clk_pkg::RESP_OKAY;
			rdata_q     <= 32'h0;
			st_q        <= ST_IDLE;
			hold_cnt_q  <= 9'h0;
			div_cnt_q   <= 4'h0;
			act_div_q   <= cpu_clk_pkg::DIV_RESET[2:0]; // [R12]
			act_sub_q   <= 1'b0;
			sub_ph_q    <= 1'b0;
			cpu_en_q    <= 1'b0;
			per_en_q    <= 1'b0;
			instr_q     <= 6'(cpu_clk_pkg::MIN_INSTR_CLKS)
				<< cpu_clk_pkg::DIV_RESET[2:0];
		end else if (i_ce) begin
			div_reg_q   <= div_reg_d;
			osc_reg_q   <= osc_reg_d;
			gain_done_q <= gain_done_d;
			aw_full_q   <= aw_full_d;
			aw_idx_q    <= aw_idx_d;
			w_full_q    <= w_full_d;
			w_byte_q    <= w_byte_d;
			w_lane_q    <= w_lane_d;
			bvalid_q    <= bvalid_d;
			bresp_q     <= bresp_d;
			rvalid_q    <= rvalid_d;
			rresp_q     <= rresp_d;
			rdata_q     <= rdata_d;
			st_q        <= st_d;
			hold_cnt_q  <= hold_cnt_d;
			div_cnt_q   <= div_cnt_d;
			act_div_q   <= act_div_d;
			act_sub_q   <= act_sub_d;
			sub_ph_q    <= sub_ph_d;
			cpu_en_q    <= cpu_en_d;
			per_en_q    <= per_en_d;
			instr_q     <= instr_d;
		end
	end
	assign o_cpu_clk_en      = cpu_en_q;
	assign o_periph_clk_en   = per_en_q;
	assign o_cpu_held        = (st_q != ST_IDLE);
	assign o_cpu_on_sub      = act_sub_q; // [R14] [R21]
	assign o_min_instr_ticks = instr_q;
	assign o_drive_gain_high = osc_reg_q[cpu_clk_pkg::B_GAIN];
	assign o_main_pin_mode   = pin_mode(osc_reg_q[cpu_clk_pkg::B_MAIN_EXT],
		osc_reg_q[cpu_clk_pkg::B_MAIN_OSC]);
	// force-start overrides the subsystem select pair
	assign o_sub_pin_mode = div_reg_q[cpu_clk_pkg::B_FORCE]
		? cpu_clk_pkg::PIN_XTAL // [R9] [R10]
		: pin_mode(osc_reg_q[cpu_clk_pkg::B_SUB_EXT],
			osc_reg_q[cpu_clk_pkg::B_SUB_OSC]); // [R10]
endmodule

// ===== verification/cpu_clk_sel_div_checker.sv
// assertions on the cpu clock block: bus handshakes, holds, clock pulses
// bound to every instance of the block; sees only its ports
`timescale 1ns/10ps
module cpu_clk_sel_div_checker (
	input wire logic       i_clk,             // clock
	input wire logic       i_rst_b,           // sync reset
	input wire logic       i_ce,              // enable
	input wire logic       i_awvalid,         // aw valid
	input wire logic       o_awready,         // aw ready
	input wire logic       i_wvalid,          // w valid
	input wire logic       o_wready,          // w ready
	input wire logic       o_bvalid,          // b valid
	input wire logic       i_arvalid,         // ar valid
	input wire logic       o_arready,         // ar ready
	input wire logic       o_rvalid,          // r valid
	input wire logic       i_main_src_hs,     // main is hs
	input wire logic       i_hs_tick,         // hs tick
	input wire logic       o_cpu_clk_en,      // cpu enable
	input wire logic       o_periph_clk_en,   // periph enable
	input wire logic       o_cpu_held,        // cpu held
	input wire logic       o_cpu_on_sub,      // on sub clock
	input wire logic       o_drive_gain_high, // gain bit
	input wire logic [5:0] o_min_instr_ticks  // ticks per 2 clocks
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	property p_wr_resp;
		i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("no bvalid");

	property p_wr_busy;
		o_bvalid |-> !o_awready && !o_wready;
	endproperty
	a_wr_busy: assert property (p_wr_busy) else $error("write overlap");

	property p_rd_resp;
		i_arvalid && o_arready |=> o_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("no rvalid");

	property p_rd_busy;
		o_rvalid |-> !o_arready;
	endproperty
	a_rd_busy: assert property (p_rd_busy) else $error("read overlap");

	// first held cycle may still carry a pulse launched before the hold
	property p_held;
		o_cpu_held && $past(o_cpu_held) |-> !o_cpu_clk_en;
	endproperty
	a_held: assert property (p_held) else $error("cpu clock not held");

	property p_periph;
		i_rst_b && i_ce && i_main_src_hs && i_hs_tick |=> o_periph_clk_en;
	endproperty
	a_periph: assert property (p_periph) else $error("periph gated");

	property p_gain;
		!$fell(o_drive_gain_high);
	endproperty
	a_gain: assert property (p_gain) else $error("gain cleared");

	property p_sub_instr;
		$rose(o_cpu_on_sub) |-> ##[0:2] (o_min_instr_ticks == 6'h04);
	endproperty
	a_sub_instr: assert property (p_sub_instr) else $error("sub ticks");
endmodule

bind cpu_clk_sel_div cpu_clk_sel_div_checker chk_u (.*);

// ===== verification/cpu_clk_sel_div_test.sv
// self-checking bench for cpu_clk_sel_div through its axi4-lite port
// makes its own oscillator tick pulses; 25 MHz clock
`timescale 1ns/10ps
module cpu_clk_sel_div_test;
	localparam logic [17:0] A_DIV = {cpu_clk_pkg::IDX_CPU_DIV, 2'h0};
	localparam logic [17:0] A_OSC = {cpu_clk_pkg::IDX_OSC_SEL, 2'h0};
	localparam logic [17:0] A_SET = {cpu_clk_pkg::IDX_DIV_SET, 2'h0};
	localparam logic [17:0] A_CLR = {cpu_clk_pkg::IDX_DIV_CLR, 2'h0};
	localparam logic [1:0]  OK    = cpu_clk_pkg::RESP_OKAY;
	localparam int          HC    = cpu_clk_pkg::HOLD_CYC;
	localparam int          HE    = 2 * cpu_clk_pkg::HOLD_EXT_CLKS;
	logic        i_clk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1;
	logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_arvalid = 1'b0;
	logic        i_bready = 1'b1, i_rready = 1'b1, i_main_src_hs = 1'b1;
	logic        i_hs_tick = 1'b0, i_ih_tick = 1'b0, i_sub_tick = 1'b0;
	logic        i_stop_release = 1'b0, i_osc_stable = 1'b0;
	logic [17:0] i_awaddr = 18'h0, i_araddr = 18'h0;
	logic [31:0] i_wdata = 32'h0;
	logic [3:0]  i_wstrb = 4'h1;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic        o_cpu_clk_en, o_periph_clk_en, o_cpu_held, o_cpu_on_sub;
	logic        o_drive_gain_high;
	logic [1:0]  o_bresp, o_rresp, o_main_pin_mode, o_sub_pin_mode;
	logic [31:0] o_rdata;
	logic [5:0]  o_min_instr_ticks;
	logic [7:0]  tk = 8'h0;
	int          miscompares = 0;
	int          cmp_count = 0;

	cpu_clk_sel_div dut_u (.*);

	always #20 i_clk = ~i_clk;

	// hs tick every 2 cycles, sub every 8, internal every 3 except at the 8-bit tk wrap
	always @(posedge i_clk) begin
		tk <= tk + 8'h1;
		i_hs_tick <= ~i_hs_tick;
		i_sub_tick <= (tk[2:0] == 3'h7);
		i_ih_tick <= (tk % 8'h3 == 8'h0);
	end

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic rst;
		@(posedge i_clk);
		i_rst_b <= 1'b0;
		repeat (4) @(posedge i_clk);
		i_rst_b <= 1'b1;
	endtask

	// for reads d is the expected byte; bready and rready stay high
	task automatic acc(input bit w, input logic [17:0] a,
		input logic [7:0] d, input logic [1:0] er);
		int n;
		bit ta, tw, tr, dn;
		logic [1:0] r;
		logic [31:0] q;
		dn = 1'b0;
		@(posedge i_clk);
		if (w) begin
			i_awaddr <= a;
			i_wdata <= {24'h0, d};
			i_awvalid <= 1'b1;
			i_wvalid <= 1'b1;
		end else begin
			i_araddr <= a;
			i_arvalid <= 1'b1;
		end
		for (n = 0; n < 100 && !dn; n++) begin
			@(negedge i_clk);
			ta = i_awvalid && o_awready;
			tw = i_wvalid && o_wready;
			tr = i_arvalid && o_arready;
			if ((w ? o_bvalid : o_rvalid) === 1'b1) begin
				dn = 1'b1;
				r = w ? o_bresp : o_rresp;
				q = o_rdata;
			end
			@(posedge i_clk);
			if (ta) i_awvalid <= 1'b0;
			if (tw) i_wvalid <= 1'b0;
			if (tr) i_arvalid <= 1'b0;
		end
		if (!dn) begin
			miscompares++;
			complete_run();
		end
		chk(r, er);
		if (!w && er == OK) chk(q, {24'h0, d});
		@(negedge i_clk);
	endtask

	// p selects the peripheral enable; skips one period after a change
	task automatic per(input bit p, input int e);
		int n, m;
		repeat (2) begin
			n = 0;
			do @(negedge i_clk);
			while (!(p ? o_periph_clk_en : o_cpu_clk_en) && ++n < 300);
		end
		for (m = 1; m < 300; m++) begin
			@(negedge i_clk);
			if (p ? o_periph_clk_en : o_cpu_clk_en) break;
		end
		chk(32'(m), 32'(e));
	endtask

	// a hold may start before the write answer returns, so allow slack
	task automatic hld(input int e);
		int n, m;
		n = 0;
		m = 0;
		do @(negedge i_clk);
		while (o_cpu_held !== 1'b1 && ++n < 50);
		while (o_cpu_held === 1'b1 && m < 1000) begin
			m++;
			@(negedge i_clk);
		end
		chk({31'h0, m >= e - 4 && m <= e + 2}, 32'h1);
	endtask

	task automatic stp;
		@(posedge i_clk);
		i_stop_release <= 1'b1;
		@(posedge i_clk);
		i_stop_release <= 1'b0;
	endtask

	initial begin
		int v;
		logic [7:0] b;
		rst();
		acc(0, A_DIV, 8'h01, OK);
		acc(0, A_OSC, 8'h00, OK);
		acc(0, 18'h0, 8'h00, cpu_clk_pkg::RESP_DECERR);
		acc(1, 18'h0, 8'h00, cpu_clk_pkg::RESP_DECERR);
		// enable low must freeze the peripheral enable and refuse the bus
		@(posedge i_clk);
		i_ce <= 1'b0;
		@(negedge i_clk);
		b = {7'h0, o_periph_clk_en};
		@(negedge i_clk);
		chk(o_periph_clk_en, 32'(b));
		chk(o_awready, 32'h0);
		chk(o_arready, 32'h0);
		@(posedge i_clk);
		i_ce <= 1'b1;
		for (v = 0; v < 5; v++) begin
			acc(1, A_DIV, 8'(v), OK);
			acc(0, A_DIV, 8'(v), OK);
			per(0, 2 << v);
			chk(o_min_instr_ticks, 32'h2 << v);
			per(1, 2);
		end
		acc(1, A_DIV, 8'h05, OK);
		acc(0, A_DIV, 8'h04, OK);
		acc(1, A_DIV, 8'h20, OK);
		acc(0, A_DIV, 8'h00, OK);
		acc(1, A_SET, 8'h10, OK);
		per(0, 16);
		chk(o_cpu_on_sub, 32'h1);
		acc(0, A_DIV, 8'h30, OK);
		acc(1, A_CLR, 8'h10, OK);
		per(0, 2);
		chk(o_cpu_on_sub, 32'h0);
		for (v = 0; v < 4; v++) begin
			b = 8'(v * 8'h50);
			acc(1, A_OSC, b, OK);
			acc(0, A_OSC, b, OK);
			chk(o_main_pin_mode, 32'(v[0] ? v : 0));
			chk(o_sub_pin_mode, 32'(v[0] ? v : 0));
		end
		acc(1, A_SET, 8'h40, OK);
		chk(o_sub_pin_mode, cpu_clk_pkg::PIN_XTAL);
		acc(1, A_CLR, 8'h40, OK);
		acc(1, A_OSC, 8'h50, OK);
		acc(1, A_OSC, 8'h51, OK);
		hld(HC);
		chk(o_drive_gain_high, 32'h1);
		acc(1, A_OSC, 8'h50, OK);
		acc(0, A_OSC, 8'h51, OK);
		stp();
		repeat (200) @(negedge i_clk);
		chk(o_cpu_held, 32'h1);
		@(posedge i_clk);
		i_osc_stable <= 1'b1;
		for (v = 0; v < 20 && o_cpu_held !== 1'b0; v++) @(negedge i_clk);
		chk(o_cpu_held, 32'h0);
		@(posedge i_clk);
		i_osc_stable <= 1'b0;
		i_main_src_hs <= 1'b0;
		stp();
		hld(HC);
		@(posedge i_clk);
		i_main_src_hs <= 1'b1;
		rst();
		acc(1, A_OSC, 8'hc0, OK);
		acc(1, A_OSC, 8'hc1, OK);
		hld(HE);
		stp();
		hld(HE);
		complete_run();
	end
endmodule
